// ===== rtl/asr_ctrl.sv
// clocked controller that runs read and write cycles on an asynchronous static memory
module asr_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [asr_pkg::ADDR_W-1:0] req_addr,
  input wire logic [asr_pkg::DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [asr_pkg::DATA_W-1:0] rsp_rdata,
  output logic [asr_pkg::ADDR_W-1:0] mem_addr,
  output logic select_active_low_n,
  output logic select_active_high,
  output logic mem_oe_n,
  output logic mem_we_n,
  input wire logic [asr_pkg::DATA_W-1:0] mem_dq_in,
  output logic [asr_pkg::DATA_W-1:0] mem_dq_out,
  output logic mem_dq_oe
);
  // ==========================================================
  // state and timing
  asr_pkg::asr_state_t state_r;
  logic wr_r;
  logic tload;
  logic [asr_pkg::CNT_W-1:0] tval;
  logic tdone;

  function automatic logic [asr_pkg::CNT_W-1:0] cyc(input int n);
    cyc = asr_pkg::CNT_W'(n - 1);
  endfunction

  asr_timer u_timer (
    .clk(clk),
    .resetn(resetn),
    .load(tload),
    .load_val(tval),
    .done(tdone)
  );

  always_comb begin
    tload = 1'b0;
    tval = 4'h0;
    case (state_r)
      asr_pkg::ST_SETUP: begin
        tload = 1'b1;
        tval = wr_r ? cyc(asr_pkg::WP_CYC) : cyc(asr_pkg::RD_CYC); // [RULE4] [RULE18]
      end
      asr_pkg::ST_END: begin
        tload = !wr_r;
        tval = cyc(asr_pkg::TURN_CYC); // [RULE17]
      end
      default: begin
        tload = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= asr_pkg::ST_IDLE;
    end else begin
      case (state_r)
        asr_pkg::ST_IDLE: if (req_valid) state_r <= asr_pkg::ST_SETUP;
        asr_pkg::ST_SETUP: state_r <= asr_pkg::ST_ACT;
        asr_pkg::ST_ACT: if (tdone) state_r <= asr_pkg::ST_END;
        asr_pkg::ST_END: state_r <= wr_r ? asr_pkg::ST_IDLE : asr_pkg::ST_TURN;
        asr_pkg::ST_TURN: if (tdone) state_r <= asr_pkg::ST_IDLE;
        default: state_r <= asr_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // request capture and address, stable across whole cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_r <= 1'b0;
      mem_addr <= '0;
      mem_dq_out <= '0;
    end else if (state_r == asr_pkg::ST_IDLE && req_valid) begin
      wr_r <= req_write;
      mem_addr <= req_addr; // strobe high and selects off here [RULE7] [RULE21]
      mem_dq_out <= req_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (state_r == asr_pkg::ST_IDLE) && !req_valid && !req_ready;
    end
  end

  // ==========================================================
  // memory pins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      select_active_low_n <= 1'b1; // standby after reset [RULE20]
      select_active_high <= 1'b0;
      mem_we_n <= 1'b1;
      mem_oe_n <= 1'b1;
      mem_dq_oe <= 1'b0;
    end else begin
      case (state_r)
        asr_pkg::ST_SETUP: begin
          select_active_low_n <= 1'b0; // both selects [RULE2] [RULE16]
          select_active_high <= 1'b1;
          mem_we_n <= !wr_r; // read holds strobe high [RULE8] [RULE5] [RULE15]
          mem_oe_n <= wr_r; // output drive only for reads [RULE10] [RULE19]
          mem_dq_oe <= wr_r; // memory floats since strobe falls with select [RULE13]
        end
        asr_pkg::ST_ACT: begin
          if (tdone) begin
            mem_we_n <= 1'b1; // strobe and selects end the write on the same edge [RULE6]
            select_active_low_n <= 1'b1; // [RULE12]
            select_active_high <= 1'b0;
            mem_oe_n <= 1'b1; // [RULE14]
          end
        end
        asr_pkg::ST_END: begin
          mem_dq_oe <= 1'b0;
        end
        default: begin
          mem_we_n <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // read return, data sampled after address and selects settled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= (state_r == asr_pkg::ST_ACT) && tdone && !wr_r; // [RULE9] [RULE11]
      if ((state_r == asr_pkg::ST_ACT) && tdone && !wr_r) begin
        rsp_rdata <= mem_dq_in; // [RULE1] [RULE3]
      end
    end
  end

  // ==========================================================
  // pulse-length counters, read only by the checks below
  logic [asr_pkg::CNT_W-1:0] wp_len_r;
  logic [asr_pkg::CNT_W-1:0] sel_len_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_len_r <= 4'h0;
    end else if (mem_we_n) begin
      wp_len_r <= 4'h0;
    end else if (wp_len_r != 4'hf) begin
      wp_len_r <= wp_len_r + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_len_r <= 4'h0;
    end else if (select_active_low_n) begin
      sel_len_r <= 4'h0;
    end else if (sel_len_r != 4'hf) begin
      sel_len_r <= sel_len_r + 4'h1;
    end
  end

  // ==========================================================
  // checks
  sequence s_rd_start;
    $fell(select_active_low_n) && mem_we_n;
  endsequence

  sequence s_wr_start;
    $fell(select_active_low_n) && !mem_we_n;
  endsequence

  sequence s_wr_end;
    $rose(mem_we_n);
  endsequence

  a_read_we_high: assert property (@(posedge clk) disable iff (!resetn) // [RULE8]
    s_rd_start |-> mem_we_n [*2]) else $error("strobe fell in read");
  a_addr_stable: assert property (@(posedge clk) disable iff (!resetn) // [RULE7]
    !mem_we_n |=> $stable(mem_addr) || mem_we_n) else $error("addr moved in write");
  a_wr_sel: assert property (@(posedge clk) disable iff (!resetn) // [RULE5]
    !mem_we_n |-> !select_active_low_n && select_active_high) else $error("bad select");
  a_no_fight: assert property (@(posedge clk) disable iff (!resetn) // [RULE17]
    mem_dq_oe |-> mem_oe_n) else $error("bus fight");
  a_turn_gap: assert property (@(posedge clk) disable iff (!resetn) // [RULE12]
    $rose(mem_oe_n) |-> !mem_dq_oe [*2]) else $error("drive too soon");
  a_wp_width: assert property (@(posedge clk) disable iff (!resetn) // [RULE18]
    s_wr_end |-> wp_len_r >= asr_pkg::WP_CYC) else $error("pulse short");
  a_sel_pair: assert property (@(posedge clk) disable iff (!resetn) // [RULE16]
    select_active_low_n == !select_active_high) else $error("selects split");
  a_rd_rsp: assert property (@(posedge clk) disable iff (!resetn) // [RULE4]
    s_rd_start |-> ##[1:4] rsp_valid) else $error("no read data");

  // ==========================================================
  // timing and ordering checks
  a_wr_float: assert property (@(posedge clk) disable iff (!resetn) // [RULE15]
    s_wr_start |-> $fell(mem_we_n) && mem_oe_n) else $error("select before strobe");
  a_data_hold: assert property (@(posedge clk) disable iff (!resetn) // [RULE6]
    s_wr_end |-> mem_dq_oe && $stable(mem_dq_out)) else $error("data lost at write end");
  a_cw_hold: assert property (@(posedge clk) disable iff (!resetn) // [RULE16]
    s_wr_end |-> sel_len_r * asr_pkg::CLK_PERIOD_NS >= asr_pkg::T_CW_NS) else $error("select short");
  a_rd_access: assert property (@(posedge clk) disable iff (!resetn) // [RULE11]
    rsp_valid |-> sel_len_r * asr_pkg::CLK_PERIOD_NS >= asr_pkg::T_AA_NS) else $error("read early");
  a_rd_sample: assert property (@(posedge clk) disable iff (!resetn) // [RULE10]
    rsp_valid |-> !$past(mem_oe_n)) else $error("read without output drive");
  a_rsp_pulse: assert property (@(posedge clk) disable iff (!resetn) // [RULE9]
    rsp_valid |=> !rsp_valid) else $error("response too long");
  a_addr_idle: assert property (@(posedge clk) disable iff (!resetn) // [RULE7]
    !$stable(mem_addr) |-> select_active_low_n && mem_we_n) else $error("addr moved selected");
  a_idle_pins: assert property (@(posedge clk) disable iff (!resetn) // [RULE20]
    select_active_low_n |-> mem_we_n && mem_oe_n) else $error("strobe active in standby");
endmodule // asr_ctrl

// ===== rtl/asr_pkg.sv
// package: timing constants, pin widths and states of the static memory controller
// Function
// RULE1: memory holds 131072 eight-bit words over one shared bidirectional byte bus.
// RULE2: two selects, one low-active, one high-active, plus output-drive control.
// RULE3: memory is fully asynchronous; controller needs no refresh activity.
// RULE4: read or write cycle lasts at least the address access time.
// RULE5: write happens only while both selects active and strobe low.
// RULE6: write ends at first of strobe rise or select release; recovery follows.
// RULE7: address changes only while strobe high or a select inactive.
// RULE8: read keeps write strobe high all cycle with both selects active.
// RULE9: read data waits for later of address valid and select assertion.
// RULE10: read data valid only after output-drive low, within output-enable access.
// RULE11: read data valid within select access time after both selects active.
// RULE12: deselect floats memory outputs within deselect float time.
// RULE13: strobe low while selected floats memory outputs within strobe float time.
// RULE14: outputs resume no sooner than output-active delay after write end.
// RULE15: selects active with or after strobe fall keep outputs floating.
// RULE16: both selects stay asserted for the whole select-to-end-of-write time.
// RULE17: controller never drives the bus while memory outputs may be driving.
// RULE18: with output drive on, write pulse covers float time plus data setup.
// RULE19: with output drive off, write pulse meets ordinary minimum width.
// RULE20: deselected memory idles in standby, bus floating, strobes ignored.
// RULE21: address bus is 17 bits wide, bit 0 least significant.
package asr_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 40;
  // timing figures of the slowest grade, in ns
  localparam int T_AA_NS = 25;
  localparam int T_WP_NS = 15;
  localparam int T_CW_NS = 15;
  localparam int T_WHZ_NS = 9;
  localparam int T_DW_NS = 10;
  localparam int T_CHZ_NS = 10;
  localparam int T_OHZ_NS = 10;
  // least times round up, at least one cycle; read time adds one cycle more
  localparam int RD_CYC = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int WP_CYC = ((T_WHZ_NS + T_DW_NS) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HZ_NS = (T_CHZ_NS > T_OHZ_NS) ? T_CHZ_NS : T_OHZ_NS;
  localparam int TURN_CYC = (HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_ACT = 3'b011,
    ST_END = 3'b010,
    ST_TURN = 3'b110
  } asr_state_t;
endpackage : asr_pkg

// ===== rtl/asr_timer.sv
// down counter that times the active phase and the read turnaround of a memory cycle
module asr_timer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [asr_pkg::CNT_W-1:0] load_val,
  output logic done
);
  logic [asr_pkg::CNT_W-1:0] cnt_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 4'h0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  assign done = (cnt_r == 4'h0) && !load;
endmodule // asr_timer

// ===== dv/asr_mem_model.sv
// behavioural static memory that answers the controller's pins
module asr_mem_model (
  input wire logic [asr_pkg::ADDR_W-1:0] mem_addr,
  input wire logic select_active_low_n,
  input wire logic select_active_high,
  input wire logic mem_oe_n,
  input wire logic mem_we_n,
  input wire logic [asr_pkg::DATA_W-1:0] mem_dq_out,
  input wire logic mem_dq_oe,
  output logic [asr_pkg::DATA_W-1:0] mem_dq_in,
  output int viol
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [asr_pkg::DATA_W-1:0] mem [0:(1<<asr_pkg::ADDR_W)-1];
  logic sel, wr, rd;
  int addr_viol = 0;
  int fight_viol = 0;
  assign sel = !select_active_low_n && select_active_high;
  assign wr = sel && !mem_we_n;
  assign rd = sel && mem_we_n && !mem_oe_n;
  // released bus shows the inverse of the addressed word, so a mistimed sample fails
  assign mem_dq_in = rd ? mem[mem_addr] : ~mem[mem_addr];
  assign viol = addr_viol + fight_viol;
  always @* if (wr && mem_dq_oe) mem[mem_addr] = mem_dq_out;
  always @(mem_addr) if (wr) addr_viol++;
  always @(mem_dq_oe or rd) if (mem_dq_oe && rd) fight_viol++;
endmodule // asr_mem_model

// ===== dv/asr_ctrl_tb_top.sv
// testbench: memory controller against the behavioural memory
module asr_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, req_valid, req_write, req_ready, rsp_valid;
  logic sel_n, sel_h, oe_n, we_n, dq_oe;
  logic [asr_pkg::ADDR_W-1:0] req_addr, mem_addr;
  logic [asr_pkg::DATA_W-1:0] req_wdata, rsp_rdata, dq_in, dq_out;
  logic [16:0] addrs [4] = '{17'h00000, 17'h1ffff, 17'h0aaaa, 17'h15555};
  logic [7:0] datas [4] = '{8'h5a, 8'hff, 8'h00, 8'ha5};
  int err_count = 0, tests_run = 0, viol;
  asr_ctrl u_asr_ctrl (.clk(clk), .resetn(resetn), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .mem_addr(mem_addr), .select_active_low_n(sel_n), .select_active_high(sel_h),
    .mem_oe_n(oe_n), .mem_we_n(we_n), .mem_dq_in(dq_in), .mem_dq_out(dq_out),
    .mem_dq_oe(dq_oe));
  asr_mem_model u_asr_mem_model (.mem_addr(mem_addr), .select_active_low_n(sel_n),
    .select_active_high(sel_h), .mem_oe_n(oe_n), .mem_we_n(we_n), .mem_dq_out(dq_out),
    .mem_dq_oe(dq_oe), .mem_dq_in(dq_in), .viol(viol));
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic request(input logic wr, input logic [16:0] a, input logic [7:0] d);
    @(negedge clk);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(negedge clk);
    req_valid = 1'b0;
    @(negedge clk);
    check({sel_n, sel_h, we_n, oe_n, dq_oe}, {2'b01, !wr, wr, wr});
    check(mem_addr, a);
    check(17'(req_ready), 17'h0);
  endtask
  task automatic reset_case(input logic [16:0] a);
    request(1'b0, a, 8'h00);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    check({sel_n, sel_h, we_n, oe_n, dq_oe}, 5'b10110);
    check(17'(rsp_valid), 17'h0);
    resetn = 1'b1;
  endtask
  task automatic write_case(input logic [16:0] a, input logic [7:0] d);
    request(1'b1, a, d);
    check(17'(dq_out), 17'(d));
    repeat (2) @(negedge clk);
    check({sel_n, sel_h, we_n, dq_oe}, 4'b1010);
    check(17'(u_asr_mem_model.mem[a]), 17'(d));
  endtask
  task automatic read_case(input logic [16:0] a, input logic [7:0] d);
    int i;
    request(1'b0, a, 8'h00);
    for (i = 0; i < 8 && rsp_valid !== 1'b1; i++) @(negedge clk);
    check(17'(i), 17'(asr_pkg::RD_CYC));
    check(17'(rsp_rdata), 17'(d));
    @(negedge clk);
    check(17'(rsp_valid), 17'h0);
    @(negedge clk);
  endtask
  task automatic end_sim();
    if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #200000;
    err_count++;
    end_sim();
  end
  initial begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 17'h00000;
    req_wdata = 8'h00;
    repeat (12) @(negedge clk);
    check({sel_n, sel_h, we_n, oe_n, dq_oe}, 5'b10110);
    resetn = 1'b1;
    for (int k = 0; k < 4; k++) write_case(addrs[k], datas[k]);
    for (int k = 0; k < 4; k++) read_case(addrs[k], datas[k]);
    write_case(addrs[1], 8'h3c);
    read_case(addrs[1], 8'h3c);
    reset_case(addrs[2]);
    read_case(addrs[0], datas[0]);
    check(17'(viol), 17'h0);
    end_sim();
  end
endmodule // asr_ctrl_tb_top
